// *** hw/uart_frame_check_consts.vh ***
// Notes on behaviour
// RULE1: receive and transmit run together, separate baud rates
// RULE2: frame checking only when frame_error_select set
// RULE3: invalid stop bit sets frame error flag
// RULE4: frame error flag sticky; software or reset clears
// RULE5: checking active: completion at stop, not last bit
// RULE6: multiprocessor enable alone turns on address recognition
// RULE7: completion flag only for matching address frames
// RULE8: mode 1: stop bit acts as ninth bit
// RULE9: mode 0: multiprocessor enable has no effect
// RULE10: accept given or broadcast match, each independent
// RULE11: given match compares bits where mask is one
// RULE12: software sets mask all ones for exact address
// RULE13: broadcast is address OR mask; zeros don't-care
// RULE14: master should use all-ones for broadcast
// RULE15: reset clears address and mask, accepting everything
// RULE16: modes 2/3: ninth bit one marks address frame
`ifndef UART_FRAME_CHECK_CONSTS_VH
`define UART_FRAME_CHECK_CONSTS_VH

// ---------------------------------------------------------------
// register indices and byte addresses (byte address = 4 * index)
// ---------------------------------------------------------------
`define IDX_SLAVE_ADDRESS_VALUE 8'ha9
`define IDX_SLAVE_ADDRESS_MASK 8'hb9
`define IDX_SERIAL_CONTROL 8'h98
`define IDX_POWER_CONTROL 8'h87
`define IDX_DATA_BUFFER 8'h99
`define OFF_SLAVE_ADDRESS_VALUE 12'h2a4
`define OFF_SLAVE_ADDRESS_MASK 12'h2e4
`define OFF_SERIAL_CONTROL 12'h260
`define OFF_POWER_CONTROL 12'h21c
`define OFF_DATA_BUFFER 12'h264
`define OFF_TX_DIVISOR 12'h300
`define OFF_RX_DIVISOR 12'h304
`define OFF_INT_STATUS 12'h308
`define OFF_INT_MASK 12'h30c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SC_BIT_FE_SM0 7
`define SC_BIT_SM1 6
`define SC_BIT_MP_EN 5
`define SC_BIT_REN 4
`define SC_BIT_TB8 3
`define SC_BIT_RB8 2
`define SC_BIT_TI 1
`define SC_BIT_RI 0
`define PC_BIT_FE_SELECT 6
`define INT_BIT_RX 0
`define INT_BIT_TX 1
`define INT_BIT_FE 2

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define RST_ADDR_REG 8'h00
`define RST_DIVISOR 16'h0035
`define TICKS_PER_BIT 4'hf
`define START_CHECK_TICK 4'h7
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** hw/baud_tick.v ***
`timescale 1ns/10ps
// ---------------------------------------------------------------
// oversampling tick: one pulse every divisor+1 clocks
// ---------------------------------------------------------------
module baud_tick (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire clear, // restart the count, no tick this cycle
  input wire [15:0] divisor, // period minus one
  output reg tick // one-cycle pulse at 16x bit rate
);
  reg [15:0] cnt;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (clear || cnt == divisor) begin
      cnt <= 16'h0000;
      tick <= !clear;
    end else begin
      cnt <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

// *** hw/uart_frame_check_addr_match.v ***
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/10ps
`include "uart_frame_check_consts.vh"
module uart_frame_check_addr_match (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire [11:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [11:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire rxd, // serial receive pin
  output wire txd, // serial transmit pin
  output wire irq // interrupt, active high level
);
  localparam RX_IDLE = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_DATA = 4'b0100;
  localparam RX_STOP = 4'b1000;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  reg [7:0] slave_address_value;
  reg [7:0] slave_address_mask;
  reg sm0, sm1, multiprocessor_enable, ren, tb8, rb8, ti;
  reg receive_complete_flag;
  reg frame_error_flag;
  reg frame_error_select;
  reg [7:0] rx_buffer;
  reg [15:0] tx_div, rx_div;
  reg [2:0] int_status, int_mask;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  reg aw_held, w_held;
  reg [11:0] aw_addr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [31:0] rd_mux;
  reg rd_hit, wr_hit;
  wire wr_do = aw_held && w_held && !s_axi_bvalid;
  wire rd_do = s_axi_arvalid && !s_axi_rvalid;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_do) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // address decode of a pending write
  always @* begin
    case (aw_addr_q)
      `OFF_SLAVE_ADDRESS_VALUE, `OFF_SLAVE_ADDRESS_MASK, `OFF_SERIAL_CONTROL,
      `OFF_POWER_CONTROL, `OFF_DATA_BUFFER, `OFF_TX_DIVISOR, `OFF_RX_DIVISOR,
      `OFF_INT_STATUS, `OFF_INT_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  wire wr_b0 = wr_do && wstrb_q[0];
  wire wr_b1 = wr_do && wstrb_q[1];
  wire wr_sc = wr_b0 && aw_addr_q == `OFF_SERIAL_CONTROL;
  wire wr_pc = wr_b0 && aw_addr_q == `OFF_POWER_CONTROL;
  wire wr_tx = wr_b0 && aw_addr_q == `OFF_DATA_BUFFER;
  wire wr_is = wr_b0 && aw_addr_q == `OFF_INT_STATUS;

  // bit 7 of serial control shows the error flag or mode bit 0
  wire [7:0] sc_read = {frame_error_select ? frame_error_flag : sm0, sm1,
    multiprocessor_enable, ren, tb8, rb8, ti, receive_complete_flag};

  always @* begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFF_SLAVE_ADDRESS_VALUE: rd_mux = {24'h000000, slave_address_value};
      `OFF_SLAVE_ADDRESS_MASK: rd_mux = {24'h000000, slave_address_mask};
      `OFF_SERIAL_CONTROL: rd_mux = {24'h000000, sc_read};
      `OFF_POWER_CONTROL: rd_mux = {25'h0000000, frame_error_select, 6'h00};
      `OFF_DATA_BUFFER: rd_mux = {24'h000000, rx_buffer};
      `OFF_TX_DIVISOR: rd_mux = {16'h0000, tx_div};
      `OFF_RX_DIVISOR: rd_mux = {16'h0000, rx_div};
      `OFF_INT_STATUS: rd_mux = {29'h00000000, int_status};
      `OFF_INT_MASK: rd_mux = {29'h00000000, int_mask};
      default: begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // receive pin synchroniser and baud ticks
  // ---------------------------------------------------------------
  reg rx_meta, rxs;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta <= 1'b1;
      rxs <= 1'b1;
    end else begin
      rx_meta <= rxd;
      rxs <= rx_meta;
    end
  end

  wire [1:0] mode = {sm0, sm1};
  // mode 0 shift-register operation is not built; serial logic idles there
  wire async_mode = mode != 2'b00;
  reg [3:0] rx_state;
  reg [3:0] rx_tcnt;
  reg [3:0] rx_bits;
  reg [8:0] rx_sh;
  wire rx_tick, tx_tick;
  wire rx_restart = rx_state == RX_IDLE && !rxs;
  reg tx_start;

  // RULE1: independent baud dividers
  baud_tick u_rx_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(rx_restart),
    .divisor(rx_div),
    .tick(rx_tick)
  );
  baud_tick u_tx_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(tx_start),
    .divisor(tx_div),
    .tick(tx_tick)
  );

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  wire rx_sample = rx_tick && rx_tcnt == `TICKS_PER_BIT;
  wire nine_bit = sm0;
  wire [3:0] last_bit = nine_bit ? 4'h8 : 4'h7;
  wire at_last = rx_state == RX_DATA && rx_sample && rx_bits == last_bit;
  wire at_stop = rx_state == RX_STOP && rx_sample;
  // RULE2: checking only in async modes with the select bit
  wire check_on = frame_error_select && async_mode;
  // RULE5: completion moves to the stop bit while checking
  wire done_now = (nine_bit && !check_on) ? at_last : at_stop;
  // RULE8: in mode 1 the stop bit stands in for the ninth bit
  wire [7:0] cand_data = (nine_bit && at_stop) ? rx_sh[7:0] : rx_sh[8:1];
  wire cand_ninth = nine_bit ? (at_stop ? rx_sh[8] : rxs) : rxs;
  // RULE11: given match over mask-one positions
  wire given_ok = ((cand_data ^ slave_address_value) & slave_address_mask) == 8'h00;
  // RULE13: broadcast from address OR mask
  wire [7:0] bcast = slave_address_value | slave_address_mask;
  wire bcast_ok = (cand_data & bcast) == bcast;
  // RULE10: either match accepts
  wire addr_ok = given_ok || bcast_ok;
  // RULE6: RULE7: RULE9: RULE16: filter on enable, ninth bit, address
  wire rx_accept = done_now && !receive_complete_flag &&
    (!multiprocessor_enable || (cand_ninth && addr_ok));
  // RULE3: invalid stop bit detected
  wire fe_event = at_stop && check_on && !rxs;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= RX_IDLE;
      rx_tcnt <= 4'h0;
      rx_bits <= 4'h0;
      rx_sh <= 9'h000;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_tcnt <= 4'h0;
          rx_bits <= 4'h0;
          if (!rxs && ren && async_mode) rx_state <= RX_START;
        end
        RX_START: begin
          if (rx_tick) begin
            rx_tcnt <= rx_tcnt + 4'h1;
            if (rx_tcnt == `START_CHECK_TICK) begin
              rx_tcnt <= 4'h0;
              // a glitch shorter than half a bit is not a start
              rx_state <= rxs ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (rx_tick) rx_tcnt <= rx_tcnt + 4'h1;
          if (rx_sample) begin
            rx_sh <= {rxs, rx_sh[8:1]};
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == last_bit) rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) rx_tcnt <= rx_tcnt + 4'h1;
          if (rx_sample) rx_state <= RX_IDLE;
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  reg tx_busy;
  reg [10:0] tx_sh;
  reg [3:0] tx_left;
  reg [3:0] tx_tcnt;
  wire tx_bit_end = tx_busy && tx_tick && tx_tcnt == `TICKS_PER_BIT;
  wire ti_event = tx_bit_end && tx_left == 4'h2;
  assign txd = tx_sh[0];

  always @* begin
    tx_start = wr_tx && !tx_busy && async_mode;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_busy <= 1'b0;
      tx_sh <= 11'h7ff;
      tx_left <= 4'h0;
      tx_tcnt <= 4'h0;
    end else if (tx_start) begin
      tx_busy <= 1'b1;
      tx_tcnt <= 4'h0;
      tx_sh <= {1'b1, nine_bit ? tb8 : 1'b1, wdata_q[7:0], 1'b0};
      tx_left <= nine_bit ? 4'hb : 4'ha;
    end else if (tx_busy) begin
      if (tx_tick) tx_tcnt <= tx_tcnt + 4'h1;
      if (tx_bit_end) begin
        tx_sh <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h1) tx_busy <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // software registers; hardware sets follow writes so they win
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      // RULE15: address and mask reset to zero
      slave_address_value <= `RST_ADDR_REG;
      slave_address_mask <= `RST_ADDR_REG;
      {sm0, sm1, multiprocessor_enable, ren, tb8, rb8, ti} <= 7'h00;
      receive_complete_flag <= 1'b0;
      frame_error_flag <= 1'b0;
      frame_error_select <= 1'b0;
      rx_buffer <= 8'h00;
      tx_div <= `RST_DIVISOR;
      rx_div <= `RST_DIVISOR;
      int_status <= 3'h0;
      int_mask <= 3'h0;
    end else begin
      if (wr_b0 && aw_addr_q == `OFF_SLAVE_ADDRESS_VALUE) slave_address_value <= wdata_q[7:0];
      if (wr_b0 && aw_addr_q == `OFF_SLAVE_ADDRESS_MASK) slave_address_mask <= wdata_q[7:0];
      if (wr_pc) frame_error_select <= wdata_q[`PC_BIT_FE_SELECT];
      if (wr_sc) begin
        // RULE4: software reaches the error flag via bit 7 only while frame_error_select is set
        if (frame_error_select) frame_error_flag <= wdata_q[`SC_BIT_FE_SM0];
        else sm0 <= wdata_q[`SC_BIT_FE_SM0];
        sm1 <= wdata_q[`SC_BIT_SM1];
        multiprocessor_enable <= wdata_q[`SC_BIT_MP_EN];
        ren <= wdata_q[`SC_BIT_REN];
        tb8 <= wdata_q[`SC_BIT_TB8];
        rb8 <= wdata_q[`SC_BIT_RB8];
        ti <= wdata_q[`SC_BIT_TI];
        receive_complete_flag <= wdata_q[`SC_BIT_RI];
      end
      if (wr_b0 && aw_addr_q == `OFF_TX_DIVISOR) tx_div[7:0] <= wdata_q[7:0];
      if (wr_b1 && aw_addr_q == `OFF_TX_DIVISOR) tx_div[15:8] <= wdata_q[15:8];
      if (wr_b0 && aw_addr_q == `OFF_RX_DIVISOR) rx_div[7:0] <= wdata_q[7:0];
      if (wr_b1 && aw_addr_q == `OFF_RX_DIVISOR) rx_div[15:8] <= wdata_q[15:8];
      if (wr_b0 && aw_addr_q == `OFF_INT_MASK) int_mask <= wdata_q[2:0];
      int_status <= (int_status & ~(wr_is ? wdata_q[2:0] : 3'h0)) |
        {fe_event, ti_event, rx_accept};
      // RULE4: sticky set, valid frames never clear it
      if (fe_event) frame_error_flag <= 1'b1;
      if (ti_event) ti <= 1'b1;
      // RULE7: flag only for accepted frames
      if (rx_accept) begin
        receive_complete_flag <= 1'b1;
        rx_buffer <= cand_data;
        rb8 <= cand_ninth;
      end
    end
  end

  assign irq = |(int_status & int_mask);
endmodule

// *** verification/uart_frame_check_addr_match_chk.sv ***
`timescale 1ns/10ps
module uart_chk (
  input wire aclk, // clock
  input wire aresetn, // reset, active low
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_wvalid, // w valid
  input wire s_axi_wready, // w ready
  input wire [1:0] s_axi_bresp, // b response
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire [31:0] s_axi_rdata, // read data
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire txd, // serial out
  input wire irq // interrupt
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  AST_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits set");
  AST_RESET_IDLE: assert property ($rose(aresetn) |-> txd && !irq)
    else $error("not idle after reset");
  AST_TX_START: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  AST_BRESP_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 ||
    s_axi_bresp == 2'h2) else $error("bad write response");
endmodule
bind uart_frame_check_addr_match uart_chk chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .txd, .irq);

// *** verification/serial_peer.sv ***
`timescale 1ns/10ps
module serial_peer #(
  parameter RX_BIT = 32,
  parameter TX_BIT = 64
) (
  input wire aclk, // system clock
  output reg rxd, // line into the device
  input wire txd // line from the device
);
  // ---------------------------------------------------------------
  // far node: sends frames lsb first, samples device output
  // ---------------------------------------------------------------
  initial rxd = 1'b1;
  task send(input [7:0] d, input nine, input b9, input stop);
    reg [9:0] f;
    integer k;
    begin
      f = {b9, d, 1'b0};
      @(posedge aclk);
      for (k = 0; k < 9 + nine; k = k + 1) begin
        rxd <= f[k];
        repeat (RX_BIT) @(posedge aclk);
      end
      // a bad stop is a short glitch, so no false start follows it
      rxd <= stop;
      repeat (RX_BIT / 2 + 4) @(posedge aclk);
      rxd <= 1'b1;
      repeat (RX_BIT * 2) @(posedge aclk);
    end
  endtask
  task grab(output [7:0] d);
    integer k;
    begin
      for (k = 0; k < 4000 && txd; k = k + 1) @(posedge aclk);
      repeat (TX_BIT + TX_BIT / 2) @(posedge aclk);
      for (k = 0; k < 8; k = k + 1) begin
        d[k] = txd;
        repeat (TX_BIT) @(posedge aclk);
      end
    end
  endtask
endmodule

// *** verification/uart_frame_check_addr_match_tb_top.sv ***
`timescale 1ns/10ps
`include "uart_frame_check_consts.vh"
module uart_frame_check_addr_match_tb_top;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [11:0] awaddr = 12'h0;
  reg [11:0] araddr = 12'h0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] wstrb = 4'hf;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, rxd, txd, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer n_fail = 0;
  integer tests_run = 0;
  reg [31:0] rd;
  reg [1:0] rs;
  reg [7:0] txb;
  always #5 aclk = ~aclk;
  uart_frame_check_addr_match uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rxd(rxd), .txd(txd), .irq(irq));
  serial_peer #(.RX_BIT(32), .TX_BIT(64)) peer (.aclk(aclk), .rxd(rxd), .txd(txd));
  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task end_of_test;
    begin
      $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task axw(input [11:0] a, input [31:0] d, output [1:0] r);
    integer k;
    reg b;
    begin
      b = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 200 && !b; k = k + 1) begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) begin
          b = 1'b1;
          r = bresp;
          bready <= 1'b0;
        end
      end
      if (!b) begin
        chk(32'h0, 32'h1);
        end_of_test;
      end
    end
  endtask
  task axr(input [11:0] a, output [31:0] d, output [1:0] r);
    integer k;
    reg b;
    begin
      b = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 200 && !b; k = k + 1) begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) begin
          b = 1'b1;
          d = rdata;
          r = rresp;
          rready <= 1'b0;
        end
      end
      if (!b) begin
        chk(32'h0, 32'h1);
        end_of_test;
      end
    end
  endtask
  // entry: control, address, mask, data, ninth bit, stop bit, accepted
  task trial(input [34:0] e);
    begin
      axw(`OFF_SLAVE_ADDRESS_VALUE, {24'h0, e[26:19]}, rs);
      axw(`OFF_SLAVE_ADDRESS_MASK, {24'h0, e[18:11]}, rs);
      axw(`OFF_SERIAL_CONTROL, {24'h0, e[34:27]}, rs);
      peer.send(e[10:3], e[34], e[2], e[1]);
      axr(`OFF_SERIAL_CONTROL, rd, rs);
      chk(rd & 32'h1, {31'h0, e[0]});
      axr(`OFF_DATA_BUFFER, rd, rs);
      if (e[0]) chk(rd, {24'h0, e[10:3]});
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`OFF_SLAVE_ADDRESS_VALUE, rd, rs);
    chk(rd, 32'h0);
    axr(`OFF_SLAVE_ADDRESS_MASK, rd, rs);
    chk(rd, 32'h0);
    axw(12'h100, 32'h1, rs);
    chk({30'h0, rs}, 32'h2);
    axr(12'h100, rd, rs);
    chk({30'h0, rs}, 32'h2);
    axw(`OFF_RX_DIVISOR, 32'h1, rs);
    axw(`OFF_TX_DIVISOR, 32'h3, rs);
    axw(`OFF_INT_MASK, 32'h7, rs);
    trial({8'hf0, 8'h00, 8'h00, 8'h5a, 3'b111});
    trial({8'hb0, 8'h56, 8'hfc, 8'h57, 3'b111});
    trial({8'hf0, 8'h56, 8'hfc, 8'h5e, 3'b110});
    trial({8'hf0, 8'h56, 8'hfc, 8'hff, 3'b111});
    trial({8'hf0, 8'h56, 8'hfc, 8'h54, 3'b010});
    trial({8'hf0, 8'hf1, 8'hfa, 8'hf0, 3'b111});
    trial({8'hf0, 8'hf1, 8'hfa, 8'hf3, 3'b110});
    trial({8'hf0, 8'hf2, 8'hfd, 8'hfb, 3'b110});
    trial({8'hf0, 8'hf1, 8'hfa, 8'hfb, 3'b111});
    trial({8'hf0, 8'h33, 8'hff, 8'h32, 3'b110});
    trial({8'h70, 8'h33, 8'hff, 8'h33, 3'b111});
    trial({8'h70, 8'h33, 8'hff, 8'h33, 3'b100});
    trial({8'h30, 8'h33, 8'hff, 8'h33, 3'b110});
    trial({8'h50, 8'h33, 8'hff, 8'h34, 3'b111});
    peer.send(8'h11, 1'b0, 1'b0, 1'b0);
    axr(`OFF_INT_STATUS, rd, rs);
    chk(rd & 32'h4, 32'h0);
    // nine-bit mode first: the mode bit is hidden once the error flag is selected
    axw(`OFF_SERIAL_CONTROL, 32'hd0, rs);
    axw(`OFF_POWER_CONTROL, 32'h40, rs);
    axw(`OFF_SERIAL_CONTROL, 32'h50, rs);
    axw(`OFF_INT_STATUS, 32'h7, rs);
    fork
      peer.send(8'h22, 1'b1, 1'b1, 1'b1);
      begin
        // between the ninth-bit sample and the stop-bit sample
        repeat (325) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
      end
    join
    chk({31'h0, irq}, 32'h1);
    axw(`OFF_INT_MASK, 32'h6, rs);
    chk({31'h0, irq}, 32'h0);
    axw(`OFF_INT_MASK, 32'h7, rs);
    axw(`OFF_INT_STATUS, 32'h7, rs);
    chk({31'h0, irq}, 32'h0);
    axw(`OFF_SERIAL_CONTROL, 32'h50, rs);
    peer.send(8'h33, 1'b1, 1'b0, 1'b0);
    axr(`OFF_SERIAL_CONTROL, rd, rs);
    chk(rd & 32'h80, 32'h80);
    axr(`OFF_INT_STATUS, rd, rs);
    chk(rd & 32'h4, 32'h4);
    axw(`OFF_SERIAL_CONTROL, 32'hd0, rs);
    peer.send(8'h44, 1'b1, 1'b0, 1'b1);
    axr(`OFF_SERIAL_CONTROL, rd, rs);
    chk(rd & 32'h80, 32'h80);
    axw(`OFF_SERIAL_CONTROL, 32'h50, rs);
    axr(`OFF_SERIAL_CONTROL, rd, rs);
    chk(rd & 32'h80, 32'h0);
    axw(`OFF_POWER_CONTROL, 32'h0, rs);
    fork
      peer.send(8'h3c, 1'b1, 1'b0, 1'b1);
      axw(`OFF_DATA_BUFFER, 32'ha5, rs);
      peer.grab(txb);
    join
    chk({24'h0, txb}, 32'ha5);
    axr(`OFF_DATA_BUFFER, rd, rs);
    chk(rd, 32'h3c);
    end_of_test;
  end
endmodule
